// *** cfe_filter_edge.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfe_filter_edge
  import cfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic comparator_clock_gate,
  input wire logic comparator_run_enable,
  input wire logic compare_raw,
  input wire cfe_edge_cfg_t edge_cfg,
  input wire cfe_pin_cfg_t pin_cfg,
  output logic compare_monitor_bit,
  output logic filtered_level,
  output logic irq_request,
  output logic event_link_pulse,
  output logic compare_result_pin_o,
  output logic compare_result_pin_oe
);
  logic sync1_reg;
  logic sync2_reg;
  logic [2:0] samp_reg;
  logic filt_reg;
  logic prev_reg;
  logic edge_reg;
  logic irq_reg;
  logic pin_reg;
  logic oe_reg;
  logic tick;
  logic live;
  logic level;
  logic hit;
  cfe_state_t state_reg;

  // clock gate low behaves as a full initialisation
  assign live = rst_b && comparator_clock_gate;

  always_ff @(posedge clock) begin
    if (!live) begin
      state_reg <= CFE_ST_IDLE;
    end else begin
      case (state_reg)
        CFE_ST_IDLE: state_reg <= CFE_ST_RUN;
        CFE_ST_RUN: state_reg <= CFE_ST_RUN;
        default: state_reg <= CFE_ST_IDLE;
      endcase
    end
  end

  // analog result is asynchronous; first flop feeds only the second
  always_ff @(posedge clock) begin
    if (!live) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= compare_raw;
      // run enable is a same-clock bit, applied after the first flop, at the second flop's input
      sync2_reg <= sync1_reg && comparator_run_enable;
    end
  end

  // monitor reflects the synchronised analog decision
  assign compare_monitor_bit = sync2_reg;

  cfe_sampler u_sampler (
    .clock(clock),
    .rst_b(live),
    .sel(edge_cfg.filter_clock_select),
    .tick(tick)
  );

  // three-sample unanimous match, output settles on next tick
  always_ff @(posedge clock) begin
    if (!live) begin
      samp_reg <= '0;
      filt_reg <= CFE_FILT_RESET;
    end else if (tick) begin
      samp_reg <= {samp_reg[1:0], sync2_reg};
      if (samp_reg == 3'h7) begin
        filt_reg <= 1'b1;
      end else if (samp_reg == 3'h0) begin
        filt_reg <= 1'b0;
      end
    end
  end

  // bypass takes the synchronised level directly
  assign level = (edge_cfg.filter_clock_select == CFE_FCK_BYPASS) ?
                 sync2_reg : filt_reg;
  assign filtered_level = filt_reg;

  // edge select; prev starts on the idle side so an active side fires
  always_comb begin
    if (edge_cfg.both_edge_select) begin
      hit = level ^ prev_reg;
    end else if (edge_cfg.edge_polarity_select) begin
      hit = prev_reg && !level;
    end else begin
      hit = !prev_reg && level;
    end
  end

  // one-cycle pulse from current versus registered level
  always_ff @(posedge clock) begin
    if (!live || state_reg == CFE_ST_IDLE) begin
      prev_reg <= !edge_cfg.both_edge_select &&
                  edge_cfg.edge_polarity_select;
      edge_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      edge_reg <= hit;
      irq_reg <= hit && edge_cfg.irq_output_enable;
    end
  end

  assign event_link_pulse = edge_reg;
  assign irq_request = irq_reg;

  // pin drive with polarity; held as input after reset
  always_ff @(posedge clock) begin
    if (!live) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      pin_reg <= level ^ pin_cfg.pin_polarity_select;
      oe_reg <= pin_cfg.pin_output_enable;
    end
  end

  // software orders latch/direction itself; registered enable gates drive
  assign compare_result_pin_o = pin_reg && oe_reg;
  assign compare_result_pin_oe = oe_reg;
endmodule
`default_nettype wire

// *** cfe_pkg.sv ***
package cfe_pkg;
  localparam logic [1:0] CFE_FCK_BYPASS = 2'h0;
  localparam logic [1:0] CFE_FCK_DIV1 = 2'h1;
  localparam logic [1:0] CFE_FCK_DIV2 = 2'h2;
  localparam logic [1:0] CFE_FCK_DIV3 = 2'h3;
  localparam int CFE_DIV1_CYCLES = 1;
  localparam int CFE_DIV2_CYCLES = 8;
  localparam int CFE_DIV3_CYCLES = 32;
  localparam int CFE_DIV_W = 6;
  localparam logic CFE_FILT_RESET = 1'b0;

  typedef struct packed {
    logic [1:0] filter_clock_select;
    logic both_edge_select;
    logic edge_polarity_select;
    logic irq_output_enable;
  } cfe_edge_cfg_t;

  typedef struct packed {
    logic pin_polarity_select;
    logic pin_output_enable;
  } cfe_pin_cfg_t;

  typedef enum logic [1:0] {
    CFE_ST_IDLE = 2'b00,
    CFE_ST_RUN = 2'b01
  } cfe_state_t;
endpackage

// *** cfe_sampler.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfe_sampler
  import cfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [CFE_DIV_W-1:0] cnt_reg;
  logic [CFE_DIV_W-1:0] limit;

  always_comb begin
    case (sel)
      CFE_FCK_DIV1: limit = CFE_DIV_W'(CFE_DIV1_CYCLES - 1);
      CFE_FCK_DIV2: limit = CFE_DIV_W'(CFE_DIV2_CYCLES - 1);
      CFE_FCK_DIV3: limit = CFE_DIV_W'(CFE_DIV3_CYCLES - 1);
      default: limit = '0;
    endcase
  end

  // three distinct sampling rates
  always_ff @(posedge clock) begin
    if (!rst_b || sel == CFE_FCK_BYPASS || cnt_reg >= limit) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CFE_DIV_W'(1);
    end
  end

  assign tick = (sel != CFE_FCK_BYPASS) && (cnt_reg >= limit);
endmodule
`default_nettype wire

// *** cfe_cmp_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfe_cmp_model (
  input wire logic above_ref,
  input wire logic comparator_run_enable,
  output logic compare_raw
);
  // small lag so the decision never moves on a sampling edge
  assign #3 compare_raw = above_ref & comparator_run_enable;
endmodule
`default_nettype wire

// *** cfe_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfe_chk
  import cfe_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic comparator_clock_gate,
  input wire cfe_edge_cfg_t edge_cfg,
  input wire cfe_pin_cfg_t pin_cfg,
  input wire logic compare_monitor_bit,
  input wire logic filtered_level,
  input wire logic irq_request,
  input wire logic event_link_pulse,
  input wire logic compare_result_pin_o,
  input wire logic compare_result_pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_irq; irq_request |-> $past(edge_cfg.irq_output_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_same; $past(edge_cfg.irq_output_enable) |->
    irq_request == event_link_pulse; endproperty
  a_same: assert property (p_same) else $error("same");
  property p_one; event_link_pulse |=> !event_link_pulse; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_edge; edge_cfg.filter_clock_select == CFE_FCK_BYPASS &&
    $changed(compare_monitor_bit) && (edge_cfg.both_edge_select ||
    compare_monitor_bit != edge_cfg.edge_polarity_select) |=>
    event_link_pulse; endproperty
  a_edge: assert property (p_edge) else $error("edge");
  property p_oe; !pin_cfg.pin_output_enable &&
    !$past(pin_cfg.pin_output_enable) |->
    !compare_result_pin_oe && !compare_result_pin_o; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_pin; compare_result_pin_oe && $stable(filtered_level) &&
    $stable(compare_monitor_bit) && $stable(edge_cfg) &&
    $stable(pin_cfg) |-> compare_result_pin_o ==
    (((edge_cfg.filter_clock_select == CFE_FCK_BYPASS) ?
    compare_monitor_bit : filtered_level) ^ pin_cfg.pin_polarity_select);
  endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_gate; !comparator_clock_gate |=> !filtered_level &&
    !irq_request && !compare_result_pin_oe; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_rst; $rose(rst_b) |-> !filtered_level &&
    !event_link_pulse && !compare_result_pin_oe; endproperty
  a_rst: assert property (p_rst) else $error("rst");
endmodule
bind cfe_filter_edge cfe_chk u_cfe_chk (.*);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import cfe_pkg::*;
;
  logic clock = 0, rst_b = 0, comparator_clock_gate = 1, above_ref = 0;
  logic comparator_run_enable = 1, compare_raw, compare_monitor_bit;
  logic filtered_level, irq_request, event_link_pulse;
  logic compare_result_pin_o, compare_result_pin_oe;
  cfe_edge_cfg_t edge_cfg = '0;
  cfe_pin_cfg_t pin_cfg = '0;
  logic [7:0] ev = 0, iq = 0;
  int bad_count = 0, cmp_count = 0;
  cfe_cmp_model u_cfe_cmp_model (.*);
  cfe_filter_edge u_cfe_filter_edge (.*);
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    ev <= ev + 8'(event_link_pulse);
    iq <= iq + 8'(irq_request);
  end
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h want %0h", $time, seen, exp);
    end
  endtask
  function logic [7:0] want(input logic both);
    return both ? 8'h02 : 8'h01;
  endfunction
  function logic [7:0] pin_want(input logic lvl);
    return 8'({(lvl ^ pin_cfg.pin_polarity_select) &&
               pin_cfg.pin_output_enable, pin_cfg.pin_output_enable});
  endfunction
  task end_sim;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hA27A9D7D));
    cyc(10);
    rst_b = 1;
    chk(8'(compare_result_pin_oe), 8'h00);
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 3; m++) begin
        // 160 cycles outlasts four slowest ticks plus sync
        edge_cfg = {2'(s), m == 0, m == 2, 1'($urandom)};
        pin_cfg = 2'($urandom);
        ev = 0;
        iq = 0;
        above_ref = 1;
        cyc(160);
        chk({compare_result_pin_o, compare_result_pin_oe},
            pin_want(1'b1));
        above_ref = 0;
        cyc(160);
        chk(ev, want(m == 0));
        chk(iq, edge_cfg.irq_output_enable ? want(m == 0) : 8'h00);
        chk({compare_result_pin_o, compare_result_pin_oe},
            pin_want(1'b0));
      end
    end
    edge_cfg = {CFE_FCK_DIV1, 3'h5};
    ev = 0;
    repeat (4) begin
      above_ref = 1;
      cyc(1 + $urandom % 2);
      above_ref = 0;
      cyc(8);
    end
    chk(ev, 8'h00);
    above_ref = 1;
    cyc(12);
    comparator_run_enable = 0;
    cyc(1);
    comparator_clock_gate = 0;
    cyc(1);
    comparator_clock_gate = 1;
    comparator_run_enable = 1;
    chk(8'(filtered_level), 8'h00);
    end_sim;
  end
  initial begin
    #400000;
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
